// >>> rtl/sgr_pkg.sv
/*
 File holds the shared constants and carriers of the bus-reset and gap-count block.
 Assumes a 125 MHz system clock and a 32-bit Avalon-MM register port.
*/
package sgr_pkg;
   // Register byte offsets
   localparam logic [3:0] SGR_OFS_PHY1    = 4'h4;
   localparam logic [3:0] SGR_OFS_PHY5    = 4'h5 * 4'h0 + 4'h8;
   localparam logic [3:0] SGR_OFS_STATUS  = 4'hC;
   // Field positions within PHY register 1 and register 5
   localparam int SGR_BIT_FULL_RST  = 7;
   localparam int SGR_BIT_HOLDOFF   = 6;
   localparam int SGR_GAP_LSB       = 0;
   localparam int SGR_BIT_SHORT_RST = 6;
   // Values
   localparam logic [5:0] SGR_GAP_MAX     = 6'h3F;
   localparam logic [5:0] SGR_GAP_RESET   = 6'h3F;
   localparam logic       SGR_HOLD_RESET  = 1'b0;
   localparam logic [1:0] SGR_RESET_LIMIT = 2'h2;
   // Bus reset durations, in microseconds and in cycles
   localparam int SGR_CLK_MHZ       = 125;
   localparam int SGR_LONG_RST_US   = 167;
   localparam int SGR_SHORT_RST_US  = 2;
   localparam int SGR_LONG_RST_CYC  = SGR_LONG_RST_US * SGR_CLK_MHZ;
   localparam int SGR_SHORT_RST_CYC = SGR_SHORT_RST_US * SGR_CLK_MHZ;
   localparam int SGR_CNT_W         = 16;

   // Configuration packet values carried in from the packet logic
   typedef struct packed
   {
      logic       valid;
      logic       holdoff;
      logic [5:0] gap;
   } sgr_cfg_t;

   typedef enum logic [1:0] {SGR_IDLE, SGR_LONG, SGR_SHORT} sgr_state_t;
endpackage

// >>> rtl/sgr_timer.sv
/*
 File holds the bus-reset duration timer.
 Assumes a load pulse with a nonzero count; done pulses once when the count runs out.
*/
`timescale 1ns/100ps
module sgr_timer
(
   input  wire logic                          clk_sys_in,
   input  wire logic                          rst_b_in,
   input  wire logic                          load_in,
   input  wire logic [sgr_pkg::SGR_CNT_W-1:0] count_in,
   output logic                               busy_out,
   output logic                               done_out
);
   import sgr_pkg::*;

   typedef struct packed
   {
      logic [SGR_CNT_W-1:0] cnt;
      logic                 busy;
      logic                 done;
   } sgr_tmr_t;

   sgr_tmr_t st_ff;
   sgr_tmr_t nxt_st;

   // Count down and pulse done on the last cycle
   always_comb
   begin
      nxt_st      = st_ff;
      nxt_st.done = 1'b0;
      if (load_in)
      begin
         nxt_st.cnt  = count_in;
         nxt_st.busy = 1'b1;
      end
      else if (st_ff.busy)
      begin
         if (st_ff.cnt <= 16'h0001)
         begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.cnt  = '0;
         end
         else
            nxt_st.cnt = st_ff.cnt - 16'h0001;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign busy_out = st_ff.busy;
   assign done_out = st_ff.done;
endmodule

// >>> rtl/sgr_top.sv
/*
 File holds the gap-count and bus-reset control with its Avalon-MM register slave.
 Assumes packet logic presents transmitted and received configuration packets as one-cycle
 strobes, and that the cable side reports every bus reset it sees as a one-cycle pulse.
*/
// Our own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
// Notes on behaviour
// [RL1] A one written to the full reset bit while idle starts a long bus reset and then initialisation.
// [RL2] Each write of register 1 also stores the written holdoff bit and gap count.
// [RL3] Holdoff and gap count load from each configuration packet sent or received; a register 1 write wins, then a sent packet.
// [RL4] Two bus resets in a row with no gap count update force the gap count to 63.
// [RL5] A reset started by a register 1 write keeps the gap count just written.
// [RL6] After a configuration packet software starts a reset with matching values.
// [RL7] Software may read register 1 back and rewrite it with the reset bit set.
// [RL8] Other register resets by software write gap 63 and keep the holdoff bit.
// [RL9] Software writes register 1 only together with the reset bit.
// [RL10] The short reset bit in register 5 starts a short reset while idle; that reset keeps the gap count.
module sgr_top
(
   input  wire logic             clk_sys_in,
   input  wire logic             rst_b_in,
   input  wire logic [3:0]       avs_address_in,
   input  wire logic             avs_read_in,
   input  wire logic             avs_write_in,
   input  wire logic [31:0]      avs_writedata_in,
   output logic      [31:0]      avs_readdata_out,
   output logic                  avs_waitrequest_out,
   input  wire sgr_pkg::sgr_cfg_t cfg_tx_in,
   input  wire sgr_pkg::sgr_cfg_t cfg_rx_in,
   input  wire logic             cable_reset_in,
   output logic                  bus_reset_out,
   output logic                  short_reset_out,
   output logic                  init_start_out,
   output logic [5:0]            gap_count_out,
   output logic                  root_holdoff_flag_out
);
   import sgr_pkg::*;

   typedef struct packed
   {
      sgr_state_t  state;
      logic [5:0]  gap;
      logic        holdoff;
      logic [1:0]  resets;
      logic        keep_gap;
      logic        ack;
      logic [31:0] rdata;
      logic        bus_rst;
      logic        short_rst;
      logic        init;
      logic [SGR_CNT_W-1:0] len;                  // Cycles spent in the running reset
   } sgr_st_t;

   // Whole block state and its next value
   sgr_st_t st_ff;
   sgr_st_t nxt_st;
   // Timer handshake
   logic    tmr_load;
   logic    tmr_done;
   logic [SGR_CNT_W-1:0] tmr_count;

   // Decode of a register access by its offset
   function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   // A request is seen while waitrequest is high and answered one cycle later; a write
   // acts only on the answer edge, where the master still holds address and data
   wire logic req      = (avs_read_in | avs_write_in) & ~st_ff.ack;
   wire logic take     = avs_write_in & st_ff.ack;
   wire logic wr1      = take & hit(avs_address_in, SGR_OFS_PHY1);
   wire logic wr5      = take & hit(avs_address_in, SGR_OFS_PHY5);
   wire logic full_go  = wr1 & avs_writedata_in[SGR_BIT_FULL_RST];
   wire logic short_go = wr5 & avs_writedata_in[SGR_BIT_SHORT_RST];
   wire logic idle     = (st_ff.state == SGR_IDLE);
   wire logic start_l  = full_go & idle;
   wire logic start_s  = short_go & idle & ~full_go;
   wire logic rst_end  = tmr_done;

   // Timer for the length of an own bus reset
   sgr_timer i_sgr_timer
   (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .load_in    (tmr_load),
      .count_in   (tmr_count),
      .busy_out   (),
      .done_out   (tmr_done)
   );

   // Load the timer with the length of the reset being started
   assign tmr_load  = start_l | start_s;
   assign tmr_count = start_l ? SGR_CNT_W'(SGR_LONG_RST_CYC) : SGR_CNT_W'(SGR_SHORT_RST_CYC);

   // Next state of register file, gap count logic and reset sequencer
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.ack   = req;
      nxt_st.init  = 1'b0;
      nxt_st.rdata = '0;
      // Cycles spent in the running bus reset, watched by the length checks
      nxt_st.len   = (st_ff.bus_rst | st_ff.short_rst) ? st_ff.len + SGR_CNT_W'(1) : '0;
      // Read data are taken at the request edge and stand in the answer cycle
      if (req & avs_read_in)
      begin
         if (hit(avs_address_in, SGR_OFS_PHY1))
            nxt_st.rdata = {24'h0, 1'b0, st_ff.holdoff, st_ff.gap};
         else if (hit(avs_address_in, SGR_OFS_STATUS))
            nxt_st.rdata = {28'h0, st_ff.resets, st_ff.short_rst, st_ff.bus_rst};
      end
      // Bus reset completion counts consecutive resets
      if (rst_end | cable_reset_in)
      begin
         if (rst_end)
            nxt_st.init = 1'b1;                                // [RL1]
         if (st_ff.state == SGR_SHORT)
            nxt_st.resets = st_ff.resets;                      // [RL10]
         else if (st_ff.keep_gap)
            nxt_st.keep_gap = 1'b0;                            // [RL5]
         else if (st_ff.resets + 2'h1 >= SGR_RESET_LIMIT)
         begin
            nxt_st.gap    = SGR_GAP_MAX;                       // [RL4]
            nxt_st.resets = SGR_RESET_LIMIT;
         end
         else
            nxt_st.resets = st_ff.resets + 2'h1;
      end
      if (rst_end)
      begin
         nxt_st.state     = SGR_IDLE;
         nxt_st.bus_rst   = 1'b0;
         nxt_st.short_rst = 1'b0;
      end
      // Packet loads win over a reset in the same cycle
      if (cfg_rx_in.valid)
      begin
         nxt_st.gap     = cfg_rx_in.gap;                       // [RL3]
         nxt_st.holdoff = cfg_rx_in.holdoff;
         nxt_st.resets  = 2'h0;
      end
      // A transmitted packet wins over a received one in the same cycle
      if (cfg_tx_in.valid)
      begin
         nxt_st.gap     = cfg_tx_in.gap;                       // [RL3]
         nxt_st.holdoff = cfg_tx_in.holdoff;
         nxt_st.resets  = 2'h0;
      end
      // Register 1 write stores both fields and marks an own reset as not counted
      if (wr1)
      begin
         nxt_st.gap      = avs_writedata_in[SGR_GAP_LSB +: 6]; // [RL2]
         nxt_st.holdoff  = avs_writedata_in[SGR_BIT_HOLDOFF];
         nxt_st.resets   = 2'h0;
         nxt_st.keep_gap = full_go;                            // [RL5]
      end
      // Own resets start only from idle; a request during a running one is refused
      if (start_l)
      begin
         nxt_st.state   = SGR_LONG;                            // [RL1]
         nxt_st.bus_rst = 1'b1;
      end
      else if (start_s)
      begin
         nxt_st.state     = SGR_SHORT;                         // [RL10]
         nxt_st.short_rst = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         // Gap count starts at its maximum and holdoff clear
         st_ff         <= '0;
         st_ff.state   <= SGR_IDLE;
         st_ff.gap     <= SGR_GAP_RESET;
         st_ff.holdoff <= SGR_HOLD_RESET;
      end
      else
         st_ff <= nxt_st;
   end

   // Outputs straight from the state register
   assign avs_readdata_out      = st_ff.rdata;
   assign avs_waitrequest_out   = ~st_ff.ack;
   assign bus_reset_out         = st_ff.bus_rst;
   assign short_reset_out       = st_ff.short_rst;
   assign init_start_out        = st_ff.init;
   assign gap_count_out         = st_ff.gap;
   assign root_holdoff_flag_out = st_ff.holdoff;

   // Checks on the guarded behaviour
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);

   // Full reset write accepted while idle
   sequence s_full_write;
      wr1 && full_go && idle;
   endsequence

   a_full_reset_start: assert property (s_full_write |=> bus_reset_out) // [RL1]
      else $error("full reset did not start");
   // Register 1 writes and configuration packets
   a_reg1_store: assert property (wr1 && !cfg_tx_in.valid |=>
      gap_count_out == $past(avs_writedata_in[5:0])) // [RL2]
      else $error("register 1 write not stored");
   a_tx_packet_load: assert property (cfg_tx_in.valid && !wr1 |=>
      gap_count_out == $past(cfg_tx_in.gap)) // [RL3]
      else $error("transmitted packet not loaded");
   a_rx_packet_load: assert property (cfg_rx_in.valid && !cfg_tx_in.valid && !wr1 |=>
      root_holdoff_flag_out == $past(cfg_rx_in.holdoff)) // [RL3]
      else $error("received packet not loaded");
   // Gap count across bus resets
   a_gap_force_max: assert property (cable_reset_in && st_ff.resets == 2'h1 &&
      !st_ff.keep_gap && idle && !wr1 && !cfg_tx_in.valid && !cfg_rx_in.valid
      |=> gap_count_out == SGR_GAP_MAX) // [RL4]
      else $error("gap count not forced to maximum");
   a_keep_written: assert property (s_full_write ##1 (!wr1 && !cfg_tx_in.valid && // [RL5]
      !cfg_rx_in.valid && !cable_reset_in)[*2] |=> gap_count_out == $past(gap_count_out, 2))
      else $error("written gap count lost");
   a_short_keeps_gap: assert property (st_ff.state == SGR_SHORT && rst_end && !wr1 &&
      !cfg_tx_in.valid && !cfg_rx_in.valid |=> $stable(gap_count_out)) // [RL10]
      else $error("short reset changed gap count");
   a_long_ends_init: assert property (bus_reset_out && tmr_done |=>
      init_start_out && !bus_reset_out) // [RL1]
      else $error("initialisation did not follow reset");
   // Bus handshake
   a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out)
      else $error("bus request not answered");

   // Register reads answer with the state seen at the request edge
   sequence s_reg1_read;
      req && avs_read_in && hit(avs_address_in, SGR_OFS_PHY1);
   endsequence

   sequence s_status_read;
      req && avs_read_in && hit(avs_address_in, SGR_OFS_STATUS);
   endsequence

   sequence s_other_read;
      req && avs_read_in && !hit(avs_address_in, SGR_OFS_PHY1) &&
         !hit(avs_address_in, SGR_OFS_STATUS);
   endsequence

   a_reg1_read: assert property (s_reg1_read |=> avs_readdata_out == // [RL7]
      {25'h0, $past(root_holdoff_flag_out), $past(gap_count_out)})
      else $error("register 1 read wrong");
   a_status_read: assert property (s_status_read |=> avs_readdata_out == // [RL1]
      {28'h0, $past(st_ff.resets), $past(short_reset_out), $past(bus_reset_out)})
      else $error("status read wrong");
   a_other_read_zero: assert property (s_other_read |=> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   a_answer_once: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low for more than one cycle");

   // Own resets start only from idle and end after their fixed length
   sequence s_short_write;
      wr5 && avs_writedata_in[SGR_BIT_SHORT_RST] && idle;
   endsequence

   a_short_reset_start: assert property (s_short_write |=> // [RL10]
      short_reset_out && !bus_reset_out)
      else $error("short reset did not start");
   a_start_refused: assert property ((full_go || short_go) && !idle && !rst_end |=>
      $stable(st_ff.state))
      else $error("reset started while another ran");
   // Reset lengths, counted in the state register
   a_long_length: assert property ($fell(bus_reset_out) |-> // [RL1]
      $past(st_ff.len) == SGR_CNT_W'(SGR_LONG_RST_CYC))
      else $error("long reset length wrong");
   a_short_length: assert property ($fell(short_reset_out) |-> // [RL10]
      $past(st_ff.len) == SGR_CNT_W'(SGR_SHORT_RST_CYC))
      else $error("short reset length wrong");
   a_init_pulse: assert property (init_start_out |=> !init_start_out) // [RL1]
      else $error("initialisation start longer than one cycle");

   // Gap count bookkeeping around bus resets
   a_first_reset_keeps: assert property (cable_reset_in && st_ff.resets == 2'h0 && // [RL4]
      idle && !st_ff.keep_gap && !wr1 && !cfg_tx_in.valid && !cfg_rx_in.valid
      |=> $stable(gap_count_out) && st_ff.resets == 2'h1)
      else $error("first bus reset changed gap count");
   a_force_keeps_holdoff: assert property (cable_reset_in && st_ff.resets == 2'h1 && // [RL4]
      idle && !st_ff.keep_gap && !wr1 && !cfg_tx_in.valid && !cfg_rx_in.valid
      |=> $stable(root_holdoff_flag_out) && st_ff.resets == SGR_RESET_LIMIT)
      else $error("forced gap count disturbed holdoff");
   a_keep_clears: assert property (rst_end && st_ff.state == SGR_LONG && // [RL5]
      st_ff.keep_gap && !wr1 && !cfg_tx_in.valid && !cfg_rx_in.valid
      |=> $stable(gap_count_out) && !st_ff.keep_gap && st_ff.resets == $past(st_ff.resets))
      else $error("own reset end lost the written gap count");
   // Loads from packets and register 1 writes
   a_tx_holdoff_load: assert property (cfg_tx_in.valid && !wr1 |=> // [RL3]
      root_holdoff_flag_out == $past(cfg_tx_in.holdoff))
      else $error("transmitted holdoff not loaded");
   a_rx_gap_load: assert property (cfg_rx_in.valid && !cfg_tx_in.valid && !wr1 |=> // [RL3]
      gap_count_out == $past(cfg_rx_in.gap))
      else $error("received gap count not loaded");
   a_reg1_holdoff: assert property (wr1 |=> // [RL2]
      root_holdoff_flag_out == $past(avs_writedata_in[SGR_BIT_HOLDOFF]))
      else $error("register 1 holdoff not stored");
endmodule

// >>> sim/sgr_node_model.sv
/*
 Far-side cable node model: sends configuration packets and bus resets.
 Assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/100ps
module sgr_node_model
(
   input  wire logic     clk_sys_in,
   output sgr_pkg::sgr_cfg_t cfg_rx_out,
   output logic          cable_reset_out
);
   // Idle lines at time zero
   initial
   begin
      cfg_rx_out      = '0;
      cable_reset_out = 1'b0;
   end
   // One-cycle packet; idle fields flip so stale data never passes for valid
   task automatic send_cfg(input logic h, input logic [5:0] g);
      cfg_rx_out <= {1'b1, h, g};
      @(posedge clk_sys_in);
      cfg_rx_out <= {1'b0, ~h, ~g};
   endtask
   // One-cycle bus reset seen from the cable
   task automatic bus_reset();
      cable_reset_out <= 1'b1;
      @(posedge clk_sys_in);
      cable_reset_out <= 1'b0;
   endtask
endmodule

// >>> sim/tb_sgr_top.sv
/*
 Self-checking bench for the gap-count and bus-reset block.
 Assumes the designer's one-cycle Avalon answer and fixed reset durations.
*/
`timescale 1ns/100ps
module tb_sgr_top;
   import sgr_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst_b, avs_read, avs_write, avs_wait, cable_rst;
   logic        bus_rst, short_rst, init_start, holdoff;
   logic [3:0]  avs_addr;
   logic [31:0] avs_wdata, avs_rdata, q;
   logic [5:0]  gap;
   sgr_cfg_t    cfg_tx, cfg_rx;
   int          n_mismatch = 0;
   int          samples_checked = 0;

   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;

   sgr_top i_sgr_top (.clk_sys_in(clk_sys), .rst_b_in(rst_b), .avs_address_in(avs_addr),
      .avs_read_in(avs_read), .avs_write_in(avs_write), .avs_writedata_in(avs_wdata),
      .avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait), .cfg_tx_in(cfg_tx),
      .cfg_rx_in(cfg_rx), .cable_reset_in(cable_rst), .bus_reset_out(bus_rst),
      .short_reset_out(short_rst), .init_start_out(init_start), .gap_count_out(gap),
      .root_holdoff_flag_out(holdoff));
   sgr_node_model i_sgr_node_model (.clk_sys_in(clk_sys), .cfg_rx_out(cfg_rx),
      .cable_reset_out(cable_rst));

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", what, exp, got);
         n_mismatch++;
      end
   endtask
   // Avalon request held until waitrequest is sampled low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      avs_addr  <= a;
      avs_write <= we;
      avs_read  <= ~we;
      avs_wdata <= d;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (avs_wait !== 1'b0 && n < 50);
      q = avs_rdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50)
      begin
         chk("waitrequest", 32'h0, 32'h1);
         stop_test();
      end
   endtask
   // Waits for the pulse that ends an own reset
   task automatic wait_init(input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clk_sys);
         n++;
      end
      while (init_start !== 1'b1 && n < lim);
      if (n >= lim)
      begin
         chk("init_start", 32'h1, 32'h0);
         stop_test();
      end
   endtask

   task automatic t_reset();
      @(negedge clk_sys);
      chk("gap", 32'h3F, gap);
      chk("holdoff", 32'h0, holdoff);
      bus(1'b0, SGR_OFS_PHY1, 32'h0);
      chk("reg1", 32'h3F, q & 32'h7F);
      bus(1'b0, 4'h0, 32'h0);
      chk("unmapped", 32'h0, q);
      $display("Test reset done");
   endtask
   task automatic t_full();
      @(posedge clk_sys);
      i_sgr_node_model.send_cfg(1'b1, 6'h07);
      repeat (2) @(negedge clk_sys);
      chk("rx gap", 32'h07, gap);
      chk("rx holdoff", 32'h1, holdoff);
      @(posedge clk_sys);
      cfg_tx <= {1'b1, 1'b0, 6'h15};
      @(posedge clk_sys);
      cfg_tx <= {1'b0, 1'b1, 6'h2A};
      repeat (2) @(negedge clk_sys);
      chk("tx gap", 32'h15, gap);
      chk("tx holdoff", 32'h0, holdoff);
      bus(1'b0, SGR_OFS_PHY1, 32'h0);
      chk("reg1 readback", 32'h15, q & 32'h7F);
      bus(1'b1, SGR_OFS_PHY1, {24'h0, 1'b1, q[6:0]});
      @(negedge clk_sys);
      chk("bus reset", 32'h1, bus_rst);
      chk("gap kept", 32'h15, gap);
      bus(1'b0, SGR_OFS_STATUS, 32'h0);
      chk("status", 32'h1, q & 32'h3);
      wait_init(SGR_LONG_RST_CYC + 100);
      repeat (2) @(negedge clk_sys);
      chk("reset end", 32'h0, bus_rst);
      chk("gap after", 32'h15, gap);
      $display("Test full reset done");
   endtask
   task automatic t_force();
      @(posedge clk_sys);
      i_sgr_node_model.bus_reset();
      repeat (2) @(negedge clk_sys);
      chk("gap one", 32'h15, gap);
      bus(1'b0, SGR_OFS_STATUS, 32'h0);
      chk("reset count one", 32'h4, q & 32'hF);
      @(posedge clk_sys);
      i_sgr_node_model.bus_reset();
      repeat (2) @(negedge clk_sys);
      chk("gap two", 32'h3F, gap);
      bus(1'b0, SGR_OFS_STATUS, 32'h0);
      chk("reset count two", 32'h8, q & 32'hF);
      $display("Test force done");
   endtask
   task automatic t_short();
      @(posedge clk_sys);
      i_sgr_node_model.send_cfg(1'b0, 6'h0C);
      bus(1'b1, SGR_OFS_PHY5, 32'h40);
      @(negedge clk_sys);
      chk("short reset", 32'h1, short_rst);
      chk("long idle", 32'h0, bus_rst);
      wait_init(SGR_SHORT_RST_CYC + 100);
      @(posedge clk_sys);
      i_sgr_node_model.bus_reset();
      repeat (2) @(negedge clk_sys);
      chk("gap short", 32'h0C, gap);
      $display("Test short reset done");
   endtask
   // Plain software reset: gap 63, holdoff kept; a short request meanwhile is refused
   task automatic t_soft();
      @(posedge clk_sys);
      i_sgr_node_model.send_cfg(1'b1, 6'h0A);
      bus(1'b0, SGR_OFS_PHY1, 32'h0);
      chk("reg1 rx", 32'h4A, q & 32'h7F);
      bus(1'b1, SGR_OFS_PHY1, {24'h0, 1'b1, q[6], 6'h3F});
      @(negedge clk_sys);
      chk("soft reset", 32'h1, bus_rst);
      chk("soft gap", 32'h3F, gap);
      chk("soft holdoff", 32'h1, holdoff);
      bus(1'b1, SGR_OFS_PHY5, 32'h40);
      @(negedge clk_sys);
      chk("short refused", 32'h0, short_rst);
      chk("long running", 32'h1, bus_rst);
      wait_init(SGR_LONG_RST_CYC + 100);
      @(negedge clk_sys);
      chk("soft gap after", 32'h3F, gap);
      chk("soft holdoff after", 32'h1, holdoff);
      $display("Test software reset done");
   endtask

   // Main sequence
   initial
   begin
      rst_b     = 1'b0;
      avs_addr  = 4'h0;
      avs_read  = 1'b0;
      avs_write = 1'b0;
      avs_wdata = 32'h0;
      cfg_tx    = '0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset();
      t_full();
      t_force();
      t_short();
      t_soft();
      stop_test();
   end
endmodule
